// File: src/emb_mem_pkg.sv
// constants for the configurable embedded memory block
// assumes a single system clock and fabric logic driving the ports
package emb_mem_pkg;

    // ************************************************************
    // geometry
    // ************************************************************
    localparam int TOTAL_BITS = 4096;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 11;
    localparam int ROWS = 256;
    localparam int ROW_AW = 8;
    localparam int LANE_W = 3;
    localparam int SHAMT_W = 4;

    // ************************************************************
    // organisation codes
    // ************************************************************
    localparam logic [1:0] CFG_256X16 = 2'h0;
    localparam logic [1:0] CFG_512X8 = 2'h1;
    localparam logic [1:0] CFG_1024X4 = 2'h2;
    localparam logic [1:0] CFG_2048X2 = 2'h3;

    localparam logic [15:0] MASK_X16 = 16'hFFFF;
    localparam logic [15:0] MASK_X8 = 16'h00FF;
    localparam logic [15:0] MASK_X4 = 16'h000F;
    localparam logic [15:0] MASK_X2 = 16'h0003;

    // ************************************************************
    // path register select bit positions
    // ************************************************************
    localparam int REG_SEL_W = 6;
    localparam int REG_DIN = 0;
    localparam int REG_DOUT = 1;
    localparam int REG_WADDR = 2;
    localparam int REG_WE = 3;
    localparam int REG_RADDR = 4;
    localparam int REG_RE = 5;

    // ************************************************************
    // clocking schemes and port modes
    // ************************************************************
    localparam logic CLK_SCHEME_SPLIT = 1'b0;
    localparam logic CLK_SCHEME_INOUT = 1'b1;
    localparam logic PORT_SINGLE = 1'b0;
    localparam logic PORT_DUAL = 1'b1;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [10:0] ADDR_RST = 11'h000;

endpackage

// File: src/embedded_memory_block.sv
// configurable 4096-bit memory block: ram, dual-port ram or preloaded rom
// assumes fabric logic on CLK drives every port; section rates come as enables
//
// Functional notes
// RULE1 - block stores 4096 bits in total
// RULE2 - organisations 256x16, 512x8, 1024x4, 2048x2
// RULE3 - words up to sixteen bits wide
// RULE4 - single-port or dual-port mode selectable
// RULE5 - write and read sections run at own rates
// RULE6 - independent section enables hold registers when low
// RULE7 - alternative: input enable, output enable pair
// RULE8 - each path register can be bypassed
// RULE9 - write strobe made internally at clock edge
// RULE10 - driver presents write signals synchronously
// RULE11 - every register clears asynchronously
// RULE12 - contents preloaded, usable as lookup rom
// RULE13 - blocks combine in parallel for width
// RULE14 - blocks cascade in depth, no latency
// RULE15 - true dual-access memory uses two blocks
// RULE16 - enables driven from global or fabric
// RULE17 - same-address read during write is undefined
`timescale 1ns/1ps

module embedded_memory_block
    import emb_mem_pkg::*;
#(
    parameter logic [TOTAL_BITS-1:0] INIT_DATA = '0
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [1:0] CFG_WIDTH,
    input wire logic PORT_MODE,
    input wire logic CLK_SCHEME,
    input wire logic ROM_MODE,
    input wire logic [REG_SEL_W-1:0] REG_SEL,
    input wire logic WR_CE,
    input wire logic RD_CE,
    input wire logic CHIP_SEL,
    input wire logic WE,
    input wire logic [ADDR_W-1:0] WADDR,
    input wire logic [DATA_W-1:0] DIN,
    input wire logic RE,
    input wire logic [ADDR_W-1:0] RADDR,
    output logic [DATA_W-1:0] DOUT
);

    // ************************************************************
    // address and lane decoding
    // ************************************************************
    // RULE2 organisation decode
    function automatic logic [ROW_AW-1:0] row_of(input logic [ADDR_W-1:0] a, input logic [1:0] cfg);
        logic [ROW_AW-1:0] r;
        r = a[7:0];
        case (cfg)
            CFG_256X16: r = a[7:0];
            CFG_512X8: r = a[8:1];
            CFG_1024X4: r = a[9:2];
            CFG_2048X2: r = a[10:3];
            default: r = a[7:0];
        endcase
        return r;
    endfunction

    function automatic logic [SHAMT_W-1:0] shamt_of(input logic [ADDR_W-1:0] a, input logic [1:0] cfg);
        logic [SHAMT_W-1:0] s;
        s = 4'h0;
        case (cfg)
            CFG_256X16: s = 4'h0;
            CFG_512X8: s = {a[0], 3'h0};
            CFG_1024X4: s = {a[1:0], 2'h0};
            CFG_2048X2: s = {a[2:0], 1'b0};
            default: s = 4'h0;
        endcase
        return s;
    endfunction

    function automatic logic [DATA_W-1:0] mask_of(input logic [1:0] cfg);
        logic [DATA_W-1:0] m;
        m = MASK_X16;
        case (cfg)
            CFG_256X16: m = MASK_X16;
            CFG_512X8: m = MASK_X8;
            CFG_1024X4: m = MASK_X4;
            CFG_2048X2: m = MASK_X2;
            default: m = MASK_X16;
        endcase
        return m;
    endfunction

    // ************************************************************
    // storage
    // ************************************************************
    // RULE1 256 rows of 16 bits
    logic [DATA_W-1:0] mem [0:ROWS-1];

    // ************************************************************
    // section enables
    // ************************************************************
    // RULE5 section rates as enables
    // RULE16 enables from any source
    wire logic wr_in_ce = WR_CE;
    // RULE7 read inputs follow input enable
    wire logic rd_in_ce = (CLK_SCHEME == CLK_SCHEME_INOUT) ? WR_CE : RD_CE;
    wire logic out_ce = RD_CE;

    // ************************************************************
    // optional input registers
    // ************************************************************
    logic [DATA_W-1:0] din_reg;
    logic [ADDR_W-1:0] waddr_reg;
    logic wsel_reg;
    logic we_reg;
    logic [ADDR_W-1:0] raddr_reg;
    logic rsel_reg;
    logic re_reg;
    logic [DATA_W-1:0] mem_q_reg;
    logic [DATA_W-1:0] dout_reg;

    // RULE11 asynchronous clear
    // RULE6 hold while enable low
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            din_reg <= DATA_RST;
            waddr_reg <= ADDR_RST;
            wsel_reg <= 1'b0;
            we_reg <= 1'b0;
        end else if (wr_in_ce) begin
            din_reg <= DIN;
            waddr_reg <= WADDR;
            wsel_reg <= CHIP_SEL;
            we_reg <= WE;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            raddr_reg <= ADDR_RST;
            rsel_reg <= 1'b0;
            re_reg <= 1'b0;
        end else if (rd_in_ce) begin
            raddr_reg <= RADDR;
            rsel_reg <= CHIP_SEL;
            re_reg <= RE;
        end
    end

    // ************************************************************
    // path selection
    // ************************************************************
    // RULE8 bypass muxes per path
    wire logic [DATA_W-1:0] din_eff = REG_SEL[REG_DIN] ? din_reg : DIN;
    wire logic [ADDR_W-1:0] waddr_eff = REG_SEL[REG_WADDR] ? waddr_reg : WADDR;
    wire logic wsel_eff = REG_SEL[REG_WADDR] ? wsel_reg : CHIP_SEL;
    wire logic we_eff = REG_SEL[REG_WE] ? we_reg : WE;
    wire logic [ADDR_W-1:0] raddr_in = REG_SEL[REG_RADDR] ? raddr_reg : RADDR;
    wire logic rsel_in = REG_SEL[REG_RADDR] ? rsel_reg : CHIP_SEL;
    wire logic re_eff = REG_SEL[REG_RE] ? re_reg : RE;

    // RULE4 single port reads at write address
    wire logic single_port = (PORT_MODE == PORT_SINGLE);
    wire logic [ADDR_W-1:0] raddr_eff = single_port ? waddr_eff : raddr_in;
    wire logic rsel_eff = single_port ? wsel_eff : rsel_in;

    // RULE14 depth cascade by select, same timing
    // RULE9 internal write strobe on clock edge
    wire logic wr_fire = we_eff & wsel_eff & wr_in_ce & ~ROM_MODE;
    wire logic rd_fire = re_eff & rsel_eff & rd_in_ce;

    wire logic [ROW_AW-1:0] wrow = row_of(waddr_eff, CFG_WIDTH);
    wire logic [SHAMT_W-1:0] wsh = shamt_of(waddr_eff, CFG_WIDTH);
    wire logic [ROW_AW-1:0] rrow = row_of(raddr_eff, CFG_WIDTH);
    wire logic [SHAMT_W-1:0] rsh = shamt_of(raddr_eff, CFG_WIDTH);
    // RULE3 narrow data in low bits
    wire logic [DATA_W-1:0] lane_mask = mask_of(CFG_WIDTH);
    wire logic [DATA_W-1:0] wr_word = (mem[wrow] & ~(lane_mask << wsh)) | ((din_eff & lane_mask) << wsh);
    wire logic [DATA_W-1:0] rd_word = (mem[rrow] >> rsh) & lane_mask;

    // ************************************************************
    // array write and preload
    // ************************************************************
    // RULE12 preload lookup contents
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int i = 0; i < ROWS; i++) begin
                mem[i] <= INIT_DATA[i*DATA_W +: DATA_W];
            end
        end else if (wr_fire) begin
            mem[wrow] <= wr_word;
        end
    end

    // ************************************************************
    // read and output path
    // ************************************************************
    // RULE17 collision read returns old row
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mem_q_reg <= DATA_RST;
        end else if (rd_fire) begin
            mem_q_reg <= rd_word;
        end
    end

    // RULE8 output stage optional
    // RULE6 output held without enable
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dout_reg <= DATA_RST;
        end else if (REG_SEL[REG_DOUT]) begin
            if (out_ce) begin
                dout_reg <= mem_q_reg;
            end
        end else if (rd_fire) begin
            dout_reg <= rd_word;
        end
    end

    // RULE13 parallel blocks share addressing
    // RULE15 second block gives second access
    assign DOUT = dout_reg;

endmodule

// File: test/emb_mem_sva.sv
// property checks on the memory block ports
// assumes it is bound into the block by the bench
`timescale 1ns/1ps
module emb_mem_sva
    import emb_mem_pkg::*;
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [1:0] CFG_WIDTH,
    input wire logic PORT_MODE,
    input wire logic CLK_SCHEME,
    input wire logic ROM_MODE,
    input wire logic [REG_SEL_W-1:0] REG_SEL,
    input wire logic WR_CE,
    input wire logic RD_CE,
    input wire logic CHIP_SEL,
    input wire logic WE,
    input wire logic [ADDR_W-1:0] WADDR,
    input wire logic [DATA_W-1:0] DIN,
    input wire logic RE,
    input wire logic [ADDR_W-1:0] RADDR,
    input wire logic [DATA_W-1:0] DOUT
);
    // all paths bypassed, dual port, split enables
    wire plain = REG_SEL == 6'h00 && PORT_MODE && !CLK_SCHEME;
    wire rd_go = plain && RE && RD_CE && CHIP_SEL;
    wire [15:0] mask = CFG_WIDTH == CFG_256X16 ? MASK_X16 : CFG_WIDTH == CFG_512X8 ? MASK_X8 :
        CFG_WIDTH == CFG_1024X4 ? MASK_X4 : MASK_X2;
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);
    sequence wr_s;
        plain && WE && WR_CE && CHIP_SEL && !ROM_MODE && CFG_WIDTH == CFG_256X16;
    endsequence
    sequence rd_s;
        rd_go && !WE && RADDR == $past(WADDR);
    endsequence
    chk_wr_rd_back:
        assert property (wr_s ##1 rd_s |=> DOUT == $past(DIN, 2)) else $error("readback wrong");
    chk_rd_ce_hold:
        assert property (plain && !RD_CE |=> $stable(DOUT)) else $error("dout moved, read enable low");
    chk_idle_hold:
        assert property (plain && !RE |=> $stable(DOUT)) else $error("dout moved without read");
    chk_desel_hold:
        assert property (plain && !CHIP_SEL |=> $stable(DOUT)) else $error("dout moved while deselected");
    chk_narrow_mask:
        assert property (rd_go |=> (DOUT & ~mask) == 16'h0000) else $error("unused dout bits set");
    chk_stage_hold:
        assert property (REG_SEL[REG_DOUT] && !RD_CE |=> $stable(DOUT)) else $error("output stage moved");
    chk_scheme_in:
        assert property (CLK_SCHEME && PORT_MODE && REG_SEL == 6'h00 && !WR_CE |=> $stable(DOUT))
            else $error("read taken, input enable low");
    chk_rst_clear:
        assert property (disable iff (1'b0) !ARST_N |-> DOUT == 16'h0000) else $error("dout not cleared");
endmodule

// File: test/fab_model.sv
// fabric logic model driving the data side of the memory block
// assumes bench requests change just after CLK rises
`timescale 1ns/1ps
module fab_model
    import emb_mem_pkg::*;
(
    input wire logic CLK,
    input wire logic req_we,
    input wire logic [ADDR_W-1:0] req_waddr,
    input wire logic [DATA_W-1:0] req_din,
    input wire logic req_re,
    input wire logic [ADDR_W-1:0] req_raddr,
    output logic we,
    output logic [ADDR_W-1:0] waddr,
    output logic [DATA_W-1:0] din,
    output logic re,
    output logic [ADDR_W-1:0] raddr
);
    logic [DATA_W-1:0] din_last = 16'h0000;
    logic [ADDR_W-1:0] raddr_last = 11'h000;
    always_ff @(posedge CLK) begin
        din_last <= din;
        raddr_last <= raddr;
    end
    assign we = req_we;
    assign waddr = req_waddr;
    assign re = req_re;
    // released lines toggle instead of holding
    assign din = req_we ? req_din : ~din_last;
    assign raddr = req_re ? req_raddr : ~raddr_last;
endmodule

// File: test/tb_top.sv
// self-checking bench for the embedded memory block
// assumes the fabric model drives the data-side ports
`timescale 1ns/1ps
module tb_top;
    import emb_mem_pkg::*;
    logic CLK = 1'b0;
    // starts high so that the fall at time zero clears the block before the first edge
    logic ARST_N = 1'b1;
    logic [1:0] cfg = CFG_256X16;
    logic pmode = PORT_DUAL, scheme = CLK_SCHEME_SPLIT, rom = 1'b0, wce = 1'b1, rce = 1'b1, sel = 1'b1;
    logic [5:0] rsel = 6'h00;
    logic w = 1'b0, r = 1'b0, we, re;
    logic [10:0] wa = 11'h000, ra = 11'h000, waddr, raddr;
    logic [15:0] d = 16'h0000, din, dout;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    always #50 CLK = ~CLK;
    fab_model fab_model_i (.CLK, .req_we(w), .req_waddr(wa), .req_din(d), .req_re(r), .req_raddr(ra),
        .we, .waddr, .din, .re, .raddr);
    embedded_memory_block #(.INIT_DATA(4096'h1234)) embedded_memory_block_i (.CLK, .ARST_N, .CFG_WIDTH(cfg),
        .PORT_MODE(pmode), .CLK_SCHEME(scheme), .ROM_MODE(rom), .REG_SEL(rsel), .WR_CE(wce), .RD_CE(rce),
        .CHIP_SEL(sel), .WE(we), .WADDR(waddr), .DIN(din), .RE(re), .RADDR(raddr), .DOUT(dout));
    task automatic conclude();
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 1000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic chk(input logic [15:0] exp);
        n_tests++;
        if (dout !== exp) begin
            error_cnt++;
            $display("BAD DOUT exp %h got %h", exp, dout);
        end
    endtask
    task automatic setup(input logic [1:0] c, input logic [5:0] rs, input logic pm, input logic sc);
        @(posedge CLK);
        cfg <= c;
        rsel <= rs;
        pmode <= pm;
        scheme <= sc;
    endtask
    task automatic wr(input logic [10:0] a, input logic [15:0] v);
        @(posedge CLK);
        w <= 1'b1;
        wa <= a;
        d <= v;
        @(posedge CLK);
        w <= 1'b0;
    endtask
    task automatic rd(input logic [10:0] a, input logic [15:0] exp, input int n);
        @(posedge CLK);
        r <= 1'b1;
        ra <= a;
        @(posedge CLK);
        r <= 1'b0;
        repeat (n) @(posedge CLK);
        #1 chk(exp);
    endtask
    // read follows the write, never shares its cycle
    task automatic rw(input logic [10:0] a, input logic [15:0] v);
        wr(a, v);
        r <= 1'b1;
        ra <= a;
        @(posedge CLK);
        r <= 1'b0;
        #1 chk(v);
    endtask
    initial begin
        ARST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        ARST_N <= 1'b1;
        @(posedge CLK);
        rom <= 1'b1;
        wr(11'h000, 16'hFFFF);
        rom <= 1'b0;
        rd(11'h000, 16'h1234, 0);
        rw(11'h0FF, 16'hA5C3);
        rw(11'h002, 16'hBEEF);
        for (int c = 1; c < 4; c++) begin
            setup(2'(c), 6'h00, PORT_DUAL, CLK_SCHEME_SPLIT);
            rd(11'((2 << c) + (1 << c) - 1), 16'(16'hBEEF >> (16 - (16 >> c))), 0);
        end
        setup(CFG_512X8, 6'h00, PORT_DUAL, CLK_SCHEME_SPLIT);
        wr(11'h004, 16'hFF12);
        setup(CFG_256X16, 6'h00, PORT_DUAL, CLK_SCHEME_SPLIT);
        rd(11'h002, 16'hBE12, 0);
        @(posedge CLK);
        wce <= 1'b0;
        rce <= 1'b0;
        wr(11'h002, 16'h0000);
        rd(11'h0FF, 16'hBE12, 0);
        @(posedge CLK);
        wce <= 1'b1;
        rce <= 1'b1;
        sel <= 1'b0;
        wr(11'h002, 16'h0000);
        rd(11'h0FF, 16'hBE12, 0);
        @(posedge CLK);
        sel <= 1'b1;
        rd(11'h002, 16'hBE12, 0);
        setup(CFG_256X16, 6'h3F, PORT_DUAL, CLK_SCHEME_SPLIT);
        wr(11'h005, 16'h1357);
        rd(11'h005, 16'h1357, 2);
        @(posedge CLK);
        rce <= 1'b0;
        setup(CFG_256X16, 6'h00, PORT_DUAL, CLK_SCHEME_INOUT);
        rce <= 1'b1;
        @(posedge CLK);
        wce <= 1'b0;
        rd(11'h0FF, 16'h1357, 0);
        @(posedge CLK);
        wce <= 1'b1;
        rd(11'h0FF, 16'hA5C3, 0);
        setup(CFG_256X16, 6'h00, PORT_SINGLE, CLK_SCHEME_SPLIT);
        wr(11'h003, 16'h2468);
        rd(11'h7FF, 16'h2468, 0);
        @(posedge CLK);
        ARST_N <= 1'b0;
        @(posedge CLK);
        #1 chk(16'h0000);
        @(posedge CLK);
        ARST_N <= 1'b1;
        setup(CFG_256X16, 6'h00, PORT_DUAL, CLK_SCHEME_SPLIT);
        rd(11'h003, 16'h0000, 0);
        conclude();
    end
endmodule
bind embedded_memory_block emb_mem_sva emb_mem_sva_i (.CLK, .ARST_N, .CFG_WIDTH, .PORT_MODE, .CLK_SCHEME,
    .ROM_MODE, .REG_SEL, .WR_CE, .RD_CE, .CHIP_SEL, .WE, .WADDR, .DIN, .RE, .RADDR, .DOUT);
